/* File: common/pxp_pkg.sv */
// ****************************************************************
// Port expander shared constants
// ****************************************************************
package pxp_pkg;

  // Fixed upper address bits per group
  localparam logic [2:0] OD_ADDR_TOP = 3'h6;
  localparam logic [2:0] PP_ADDR_TOP = 3'h5;

  // Pin states after reset
  localparam logic [7:0] OD_RST_VAL = 8'hFF;
  localparam logic [7:0] PP_RST_VAL = 8'h00;

  // Bit index of the last bit of a byte
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Synchroniser width: scl, sda, two groups, two selects, toggle
  localparam int SYNC_W = 23;

  // Strap level seen on an address-select input
  typedef enum logic [1:0] {
    LVL_GND = 2'h0,
    LVL_SUP = 2'h1,
    LVL_SDA = 2'h2,
    LVL_SCL = 2'h3
  } pxp_lvl_type;

  // Protocol engine states
  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_ADDR  = 3'h1,
    S_ACKA  = 3'h2,
    S_WDATA = 3'h3,
    S_ACKW  = 3'h4,
    S_RDATA = 3'h5,
    S_MACK  = 3'h6,
    S_IGN   = 3'h7
  } pxp_state_type;

  // High select strap to address bits 3:2
  function automatic logic [1:0] sel_high_bits(logic [1:0] lvl);
    case (lvl)
      LVL_SCL: sel_high_bits = 2'h0;
      LVL_SDA: sel_high_bits = 2'h1;
      LVL_GND: sel_high_bits = 2'h2;
      default: sel_high_bits = 2'h3;
    endcase
  endfunction

  // Low select strap to address bits 1:0
  function automatic logic [1:0] sel_low_bits(logic [1:0] lvl);
    case (lvl)
      LVL_GND: sel_low_bits = 2'h0;
      LVL_SUP: sel_low_bits = 2'h1;
      LVL_SCL: sel_low_bits = 2'h2;
      default: sel_low_bits = 2'h3;
    endcase
  endfunction

  // Received seven address bits against one group address
  function automatic logic addr_hit(logic [6:0] rx, logic [2:0] top,
                                    logic [3:0] low);
    addr_hit = (rx == {top, low});
  endfunction

endpackage

/* File: common/pxp_bit_if.sv */
`timescale 1ns/1ps
// ****************************************************************
// Bit hand-over from the serial clock domain
// ****************************************************************
interface pxp_bit_if;
  logic smp_bit;
  logic smp_tgl;

  modport link (output smp_bit, output smp_tgl);
  modport core (input smp_bit, input smp_tgl);
endinterface

/* File: hdl/pxp_sync.sv */
`timescale 1ns/1ps
// ****************************************************************
// Two-stage level synchroniser
// ****************************************************************
module pxp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

/* File: hdl/pxp_scl_sampler.sv */
`timescale 1ns/1ps
// ****************************************************************
// Serial data capture on the link clock
// ****************************************************************
module pxp_scl_sampler (
  input  wire logic scl_clk,
  input  wire logic rst_n,
  input  wire logic sda_i,
  pxp_bit_if.link   lnk
);

  // Data bit held stable until the next rising edge; toggle marks it
  always_ff @(posedge scl_clk or negedge rst_n) begin
    if (!rst_n) begin
      lnk.smp_bit <= 1'b1;
      lnk.smp_tgl <= 1'b0;
    end else begin
      lnk.smp_bit <= sda_i;
      lnk.smp_tgl <= ~lnk.smp_tgl;
    end
  end

endmodule

/* File: hdl/pxp_expander.sv */
`timescale 1ns/1ps
// Overview of operation
// - Input change during an open-drain read reasserts the alert at that STOP.
// - No new alert during an open-drain read until it ends.
// - Each returned input byte is sampled at the acknowledge before it.
// - Push-pull reads return sensed pin levels for every byte.
// - Open-drain read address is acknowledged and pins sampled then.
// - Alert released during the open-drain read address acknowledge.
// - One-byte read sends pins, clears flags, restarts detection.
// - Snapshot equals exactly the pin byte sent to the master.
// - Released alert stays high until the read's STOP.
// - Two-byte read sends pins then flags; flags cleared.
// - Push-pull read address acknowledged, sensed levels captured.
// - Readback shows sensed level, not the programmed value.
// - Push-pull multibyte read resamples at each acknowledge.
// - Write address acknowledged; open-drain pins sampled during it for an open-drain write only.
// - Write acknowledge releases alert only for the open-drain group.
// - Every written data byte acknowledged and applied until STOP.
// - All eight bits of a byte reach the pins together.
// - Upper address bits 110 open-drain, 101 push-pull; low four shared.
// - Each select input decodes four strap levels into two bits.
// - Inputs compared with snapshot; per-pin flags latch, alert asserts.
// - Longer open-drain reads alternate fresh pins and fresh flags.
module pxp_expander (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic [7:0] open_drain_io_group_i,
  output logic      [7:0] open_drain_io_group_o,
  output logic      [7:0] open_drain_io_group_oe,
  input  wire logic [7:0] push_pull_output_group_i,
  output logic      [7:0] push_pull_output_group_o,
  input  wire logic [1:0] addr_select_low,
  input  wire logic [1:0] addr_select_high,
  output logic            alert_n
);

  // ****************************************************************
  // Reset release and synchronisers
  // ****************************************************************
  logic                   rst_a_r;
  logic                   rst_s_n;
  logic [pxp_pkg::SYNC_W-1:0] sync_q;
  logic                   scl_s;
  logic                   sda_s;
  logic [7:0]             od_in_s;
  logic [7:0]             pp_in_s;
  logic [1:0]             sel_hi_s;
  logic [1:0]             sel_lo_s;
  logic                   tgl_s;
  pxp_bit_if              lnk ();

  // Reset asserts at once, releases after two edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_a_r <= 1'b0;
      rst_s_n <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_s_n <= rst_a_r;
    end
  end

  pxp_sync #(
    .W (pxp_pkg::SYNC_W)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),  // Filled before the logic leaves reset
    .d     ({scl_i, sda_i, open_drain_io_group_i,
             push_pull_output_group_i, addr_select_high,
             addr_select_low, lnk.smp_tgl}),
    .q     (sync_q)
  );

  // Unpack synchronised inputs
  assign {scl_s, sda_s, od_in_s, pp_in_s, sel_hi_s, sel_lo_s, tgl_s} =
    sync_q;

  pxp_scl_sampler u_sampler (
    .scl_clk (scl_i),
    .rst_n   (rst_s_n),
    .sda_i   (sda_i),
    .lnk     (lnk.link)
  );

  // ****************************************************************
  // Bus events
  // ****************************************************************
  logic scl_d_r;
  logic sda_d_r;
  logic tgl_d_r;
  logic start_ev;
  logic stop_ev;
  logic fall_ev;
  logic rise_ev;
  logic rx_bit;

  // Previous pin levels for edge detection
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      tgl_d_r <= 1'b0;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      tgl_d_r <= tgl_s;
    end
  end

  // Data edges while clock high frame the transfer
  assign start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_ev  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign fall_ev  = scl_d_r & ~scl_s;
  assign rise_ev  = tgl_s ^ tgl_d_r;
  assign rx_bit   = lnk.smp_bit;  // Stable until next toggle

  // ****************************************************************
  // Protocol engine
  // ****************************************************************
  pxp_pkg::pxp_state_type state_r;
  logic [2:0] cnt_r;
  logic [7:0] rx_r;
  logic [7:0] rx_byte;
  logic [3:0] sel_bits;
  logic       match_od;
  logic       match_pp;
  logic       grp_pp_r;
  logic       rd_r;
  logic       phase_r;

  // Low address bits from the two straps
  assign sel_bits = {pxp_pkg::sel_high_bits(sel_hi_s),
                     pxp_pkg::sel_low_bits(sel_lo_s)};
  assign match_od = pxp_pkg::addr_hit(rx_r[6:0], pxp_pkg::OD_ADDR_TOP,
                                      sel_bits);
  assign match_pp = pxp_pkg::addr_hit(rx_r[6:0], pxp_pkg::PP_ADDR_TOP,
                                      sel_bits);
  assign rx_byte  = {rx_r[6:0], rx_bit};

  // Receive shift register
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      rx_r <= '0;
    end else if (rise_ev) begin
      rx_r <= rx_byte;
    end
  end

  // State, bit count, group and direction
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      state_r  <= pxp_pkg::S_IDLE;
      cnt_r    <= '0;
      grp_pp_r <= 1'b0;
      rd_r     <= 1'b0;
      phase_r  <= 1'b0;
    end else if (start_ev) begin
      state_r <= pxp_pkg::S_ADDR;
      cnt_r   <= '0;
    end else if (stop_ev) begin
      state_r <= pxp_pkg::S_IDLE;
    end else if (rise_ev) begin
      case (state_r)
        pxp_pkg::S_ADDR: begin
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == pxp_pkg::LAST_BIT) begin
            if (match_od | match_pp) begin
              state_r  <= pxp_pkg::S_ACKA;
              grp_pp_r <= match_pp;
              rd_r     <= rx_bit;
            end else begin
              state_r <= pxp_pkg::S_IGN;
            end
          end
        end
        pxp_pkg::S_ACKA: begin
          state_r <= rd_r ? pxp_pkg::S_RDATA : pxp_pkg::S_WDATA;
          cnt_r   <= '0;
          phase_r <= 1'b1;
        end
        pxp_pkg::S_WDATA: begin
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == pxp_pkg::LAST_BIT) begin
            state_r <= pxp_pkg::S_ACKW;
          end
        end
        pxp_pkg::S_ACKW: begin
          state_r <= pxp_pkg::S_WDATA;
          cnt_r   <= '0;
        end
        pxp_pkg::S_RDATA: begin
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == pxp_pkg::LAST_BIT) begin
            state_r <= pxp_pkg::S_MACK;
          end
        end
        pxp_pkg::S_MACK: begin
          if (rx_bit) begin
            state_r <= pxp_pkg::S_IGN;
          end else begin
            state_r <= pxp_pkg::S_RDATA;
            cnt_r   <= '0;
            phase_r <= ~phase_r;
          end
        end
        default: state_r <= state_r;
      endcase
    end
  end

  // ****************************************************************
  // Sampling, snapshot and change flags
  // ****************************************************************
  logic       ack_rd_ev;
  logic       od_pins_ev;
  logic       od_flag_ev;
  logic       od_wr_ev;
  logic       snap_ev;
  logic       pp_rd_ev;
  logic       wr_byte_ev;
  logic [7:0] snap_r;
  logic [7:0] flags_r;
  logic [7:0] flag_hold_r;
  logic [7:0] tx_r;
  logic [7:0] diff;

  // Acknowledge bits that load the next byte to send
  assign ack_rd_ev  = rise_ev & (((state_r == pxp_pkg::S_ACKA) & rd_r) |
                      ((state_r == pxp_pkg::S_MACK) & ~rx_bit));
  assign od_pins_ev = ack_rd_ev & ~grp_pp_r &
                      ((state_r == pxp_pkg::S_ACKA) | ~phase_r);
  assign od_flag_ev = ack_rd_ev & ~grp_pp_r &
                      (state_r == pxp_pkg::S_MACK) & phase_r;
  assign od_wr_ev   = rise_ev & (state_r == pxp_pkg::S_ACKA) & ~rd_r &
                      ~grp_pp_r;
  assign snap_ev    = od_pins_ev | od_wr_ev;
  assign pp_rd_ev   = ack_rd_ev & grp_pp_r;
  assign wr_byte_ev = rise_ev & (state_r == pxp_pkg::S_WDATA) &
                      (cnt_r == pxp_pkg::LAST_BIT);
  assign diff       = od_in_s ^ snap_r;

  // Snapshot reload; pending flags handed to the flag byte
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      snap_r      <= pxp_pkg::OD_RST_VAL;
      flags_r     <= '0;
      flag_hold_r <= '0;
    end else if (snap_ev) begin
      snap_r      <= od_in_s;
      flags_r     <= '0;
      flag_hold_r <= flags_r | diff;
    end else begin
      flags_r     <= flags_r | diff;
    end
  end

  // Transmit byte: pins, flags or push-pull readback
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      tx_r <= '0;
    end else if (od_pins_ev) begin
      tx_r <= od_in_s;
    end else if (od_flag_ev) begin
      tx_r <= flag_hold_r;
    end else if (pp_rd_ev) begin
      tx_r <= pp_in_s;
    end else if (rise_ev && state_r == pxp_pkg::S_RDATA) begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  // ****************************************************************
  // Data line drive
  // ****************************************************************
  // Changes after a falling clock edge; released at START or STOP
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      sda_oe <= 1'b0;
    end else if (start_ev || stop_ev) begin
      sda_oe <= 1'b0;
    end else if (fall_ev) begin
      case (state_r)
        pxp_pkg::S_ACKA:  sda_oe <= 1'b1;
        pxp_pkg::S_ACKW:  sda_oe <= 1'b1;
        pxp_pkg::S_RDATA: sda_oe <= ~tx_r[7];
        default:          sda_oe <= 1'b0;
      endcase
    end
  end

  assign sda_o = 1'b0;

  // ****************************************************************
  // Port outputs and change alert
  // ****************************************************************
  logic [7:0] od_low_r;
  logic [7:0] pp_out_r;
  logic       hold_r;

  // Whole byte lands on the pins in one edge
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      od_low_r <= ~pxp_pkg::OD_RST_VAL;
      pp_out_r <= pxp_pkg::PP_RST_VAL;
    end else if (wr_byte_ev) begin
      if (grp_pp_r) begin
        pp_out_r <= rx_byte;
      end else begin
        od_low_r <= ~rx_byte;
      end
    end
  end

  // Alert held off from an open-drain read's address acknowledge to STOP
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      hold_r <= 1'b0;
    end else if (stop_ev) begin
      hold_r <= 1'b0;
    end else if (od_pins_ev && state_r == pxp_pkg::S_ACKA) begin
      hold_r <= 1'b1;
    end
  end

  // Registered active-low alert
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      alert_n <= 1'b1;
    end else begin
      alert_n <= ~((|flags_r) & ~hold_r);
    end
  end

  assign open_drain_io_group_o    = '0;
  assign open_drain_io_group_oe   = od_low_r;
  assign push_pull_output_group_o = pp_out_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_s_n);

  sequence stop_flagged;
    stop_ev && hold_r && (|flags_r);
  endsequence

  sequence alert_drops;
    ##2 !alert_n;
  endsequence

  stop_reassert_a: assert property (stop_flagged |-> alert_drops)
    else $error("alert not reasserted after STOP");
  held_alert_a: assert property (hold_r && $past(hold_r) |-> alert_n)
    else $error("alert low while held in a read");
  snap_equal_a: assert property (od_pins_ev |=> snap_r == tx_r)
    else $error("snapshot differs from sent byte");
  flags_clear_a: assert property (snap_ev |=> flags_r == 8'h00)
    else $error("flags not cleared at acknowledge");
  flag_byte_a: assert property (
    od_flag_ev |=> tx_r == $past(flag_hold_r))
    else $error("flag byte not loaded");
  pp_sense_a: assert property (pp_rd_ev |=> tx_r == $past(pp_in_s))
    else $error("readback not the sensed level");
  od_write_a: assert property (wr_byte_ev && !grp_pp_r |=>
    open_drain_io_group_oe == ~$past(rx_byte))
    else $error("open-drain byte not applied");
  pp_write_a: assert property (wr_byte_ev && grp_pp_r |=>
    push_pull_output_group_o == $past(rx_byte))
    else $error("push-pull byte not applied");
  addr_ack_a: assert property (
    state_r == pxp_pkg::S_ACKA && fall_ev && !start_ev |=> sda_oe)
    else $error("address not acknowledged");
  ignore_quiet_a: assert property (
    state_r == pxp_pkg::S_IGN |-> !sda_oe)
    else $error("data line driven while ignoring");

endmodule

/* File: sim/pxp_i2c_master.sv */
`timescale 1ns/1ps
// ****************************************************************
// Bus master model: makes the serial clock, drives data
// ****************************************************************
module pxp_i2c_master #(
  parameter int Q = 10
) (
  input  wire logic clk,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_drv
);
  // Idle bus, both lines high; clock still outside frames
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic edge_n(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One clock pulse, bus sampled mid-high
  task automatic clk_pulse(output logic s);
    edge_n(Q);
    scl <= 1'b1;
    edge_n(Q / 2);
    s = sda_in;
    edge_n(Q / 2);
    scl <= 1'b0;
  endtask

  // Data falls while clock high
  task automatic start();
    edge_n(Q);
    sda_drv <= 1'b0;
    edge_n(Q);
    scl <= 1'b0;
  endtask

  // Eight bits MSB first, then the receiver's ack slot
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      edge_n(2);
      sda_drv <= b[i];
      clk_pulse(s);
    end
    edge_n(2);
    sda_drv <= 1'b1;
    clk_pulse(ack);
  endtask

  // Eight bits in; then ack, or nack when nack is set
  task automatic recv(output logic [7:0] b, input logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_pulse(s);
      b[i] = s;
    end
    edge_n(2);
    sda_drv <= nack;
    clk_pulse(s);
    edge_n(2);
    sda_drv <= 1'b1;
  endtask

  // Data rises while clock high
  task automatic stop();
    edge_n(2);
    sda_drv <= 1'b0;
    edge_n(Q);
    scl <= 1'b1;
    edge_n(Q);
    sda_drv <= 1'b1;
    edge_n(Q);
  endtask
endmodule

/* File: sim/pxp_expander_tb_top.sv */
`timescale 1ns/1ps
// ****************************************************************
// Testbench top
// ****************************************************************
module pxp_expander_tb_top;
  localparam logic [6:0] OD_A  = 7'h68;
  localparam logic [6:0] PP_A  = 7'h58;
  localparam logic [6:0] BAD_A = 7'h7F;

  logic       clk;
  logic       rst_n;
  logic       scl;
  logic       sda_drv;
  logic       sda_oe;
  logic       sda_bus;
  logic [7:0] od_ext;
  logic [7:0] od_oe;
  logic [7:0] od_pin;
  logic [7:0] pp_o;
  logic [7:0] pp_pin;
  logic       pp_frc;
  logic [7:0] pp_val;
  logic       alert_n;
  logic       ack;
  logic [7:0] rb;
  int         mismatches;
  int         tests_run;

  // Pull-ups on the bus and open-drain pins; forced readback
  assign sda_bus = sda_drv & ~sda_oe;
  assign od_pin  = od_ext & ~od_oe;
  assign pp_pin  = pp_frc ? pp_val : pp_o;

  pxp_expander pxp_expander_inst (
    .clk                      (clk),
    .rst_n                    (rst_n),
    .scl_i                    (scl),
    .sda_i                    (sda_bus),
    .sda_o                    (),
    .sda_oe                   (sda_oe),
    .open_drain_io_group_i    (od_pin),
    .open_drain_io_group_o    (),
    .open_drain_io_group_oe   (od_oe),
    .push_pull_output_group_i (pp_pin),
    .push_pull_output_group_o (pp_o),
    .addr_select_low          (pxp_pkg::LVL_GND),
    .addr_select_high         (pxp_pkg::LVL_GND),
    .alert_n                  (alert_n)
  );

  pxp_i2c_master #(.Q(10)) pxp_i2c_master_inst (
    .clk     (clk),
    .sda_in  (sda_bus),
    .scl     (scl),
    .sda_drv (sda_drv)
  );

  // Clock
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // START plus address byte, ack compared
  task automatic addr(input logic [6:0] a, input logic rw,
                      input logic exp_ack);
    pxp_i2c_master_inst.start();
    pxp_i2c_master_inst.send({a, rw}, ack);
    check("addr_ack", {7'h00, ack}, {7'h00, exp_ack});
  endtask

  task automatic send_chk(input logic [7:0] d);
    pxp_i2c_master_inst.send(d, ack);
    check("data_ack", {7'h00, ack}, 8'h00);
  endtask

  task automatic rd(input logic nack, input logic [7:0] exp);
    pxp_i2c_master_inst.recv(rb, nack);
    check("read_byte", rb, exp);
  endtask

  task automatic alert_is(input logic exp);
    repeat (8) @(posedge clk);
    check("alert_n", {7'h00, alert_n}, {7'h00, exp});
  endtask

  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    close_out();
  end

  // Main sequence
  initial begin
    rst_n      = 1'b0;
    od_ext     = 8'hFF;
    pp_frc     = 1'b0;
    pp_val     = 8'h00;
    mismatches = 0;
    tests_run  = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    check("pp_rst", pp_o, pxp_pkg::PP_RST_VAL);
    check("od_oe_rst", od_oe, 8'h00);
    alert_is(1'b1);
    $display("test reset done");
    // Open-drain write of all ones, then one pin falls
    addr(OD_A, 1'b0, 1'b0);
    send_chk(8'hFF);
    check("od_oe", od_oe, 8'h00);
    pxp_i2c_master_inst.stop();
    @(posedge clk) od_ext <= 8'hFE;
    alert_is(1'b0);
    $display("test change detect done");
    // Two-byte read with a change between bytes
    addr(OD_A, 1'b1, 1'b0);
    alert_is(1'b1);
    rd(1'b0, 8'hFE);
    @(posedge clk) od_ext <= 8'hFC;
    rd(1'b1, 8'h01);
    alert_is(1'b1);
    check("sda_oe_nack", {7'h00, sda_oe}, 8'h00);
    pxp_i2c_master_inst.stop();
    alert_is(1'b0);
    $display("test two byte read done");
    // Three-byte read alternates pins and flags
    addr(OD_A, 1'b1, 1'b0);
    rd(1'b0, 8'hFC);
    rd(1'b0, 8'h02);
    rd(1'b1, 8'hFC);
    pxp_i2c_master_inst.stop();
    alert_is(1'b1);
    $display("test long read done");
    // One-byte read, pins change during the byte
    addr(OD_A, 1'b1, 1'b0);
    @(posedge clk) od_ext <= 8'hF8;
    rd(1'b1, 8'hFC);
    pxp_i2c_master_inst.stop();
    alert_is(1'b0);
    $display("test one byte read done");
    // Push-pull write of two bytes; alert left alone
    addr(PP_A, 1'b0, 1'b0);
    alert_is(1'b0);
    send_chk(8'hA5);
    check("pp_o", pp_o, 8'hA5);
    send_chk(8'h3C);
    check("pp_o", pp_o, 8'h3C);
    pxp_i2c_master_inst.stop();
    $display("test push pull write done");
    // Open-drain write releases alert, drives pins
    addr(OD_A, 1'b0, 1'b0);
    alert_is(1'b1);
    send_chk(8'h0F);
    check("od_oe", od_oe, 8'hF0);
    pxp_i2c_master_inst.stop();
    $display("test open drain write done");
    // Push-pull readback with pins forced elsewhere
    @(posedge clk) begin
      pp_frc <= 1'b1;
      pp_val <= 8'h81;
    end
    addr(PP_A, 1'b1, 1'b0);
    @(posedge clk) pp_val <= 8'h42;
    rd(1'b0, 8'h81);
    rd(1'b1, 8'h42);
    pxp_i2c_master_inst.stop();
    $display("test push pull read done");
    // Foreign address is not acknowledged
    addr(BAD_A, 1'b0, 1'b1);
    pxp_i2c_master_inst.send(8'h00, ack);
    check("foreign_ack", {7'h00, ack}, 8'h01);
    check("od_oe_kept", od_oe, 8'hF0);
    pxp_i2c_master_inst.stop();
    $display("test foreign address done");
    close_out();
  end
endmodule
